// [logic/scm_top.sv]
// System clock selection and operating mode sequencing, with Avalon-MM registers
// Functional notes
// RQ1: System clock comes from divided high-speed clock or sub_clk; division up to 64.
// RQ2: With speed bit 0, codes 000/001 pick sub_clk, 010..111 pick divide 64..2.
// RQ3: High-speed source is crystal or RC, fixed by static configuration.
// RQ4: sub_clk source is low-speed crystal or RC, fixed by static configuration.
// RQ5: sub_clk and timebase_clk each take a configured low-speed oscillator.
// RQ6: After wake-up the processor may run from sub_clk for faster wake.
// RQ7: fast_wake_en 1 substitutes sub_clk after wake; only with crystal source.
// RQ8: Switching system clock to sub_clk stops the high-speed oscillator.
// RQ9: Normal mode runs processor from high-speed clock divided 1..64, sub and timebase on.
// RQ10: Slow mode runs processor from low-speed clock, high-speed clock off.
// RQ11: Halt with idle_on_halt 0 stops processor and enters a sleep mode.
// RQ12: deep_sleep stops processor, sub_clk, timebase_clk and watchdog.
// RQ13: deep_sleep refused while lowvolt_detect_en is 1.
// RQ14: sleep_keep_sub stops processor and timebase; sub_clk kept for watchdog on sub_clk.
// RQ15: Halt with idle_on_halt 1, keep 0 enters idle_clk_stop; oscillator stops.
// RQ16: Halt with idle_on_halt 1, keep 1 enters idle_clk_run; oscillator runs.
// RQ17: Idle modes keep peripherals working while the processor has no clock.
// RQ18: Read-only ls_osc_ready flag shows low-speed oscillator stability.
// RQ19: Wake-up resumes in the running mode set by speed and divide bits.
`timescale 1ns/10ps
`default_nettype none
`include "scm_consts.svh"
module scm_top #(
  parameter int MAX_DIV = `SCM_MAX_DIV
) (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic [3:0] I_AVS_ADDRESS,
  input wire logic I_AVS_READ,
  input wire logic I_AVS_WRITE,
  input wire logic [31:0] I_AVS_WRITEDATA,
  input wire logic [3:0] I_AVS_BYTEENABLE,
  output logic [31:0] O_AVS_READDATA,
  output logic O_AVS_WAITREQUEST,
  input wire logic I_HALT,
  input wire logic I_WAKE,
  input wire logic I_LXT_CLK,
  input wire logic I_LS_RC_OSC_CLK,
  input wire logic I_LS_OSC_READY,
  input wire logic I_HS_OSC_READY,
  input wire logic I_CFG_HS_XTAL,
  input wire logic I_CFG_SUB_LXT,
  input wire logic I_CFG_TBC_LXT,
  output logic O_HS_XTAL_SEL,
  output logic O_HS_OSC_EN,
  output logic O_CPU_CLK_EN,
  output logic O_SYS_CLK_EN,
  output logic O_SUB_CLK_EN,
  output logic O_TBC_CLK_EN,
  output logic O_WDT_RUN,
  output logic O_PERIPH_RUN,
  output scm_pkg::scm_mode_t O_MODE
);
  import scm_pkg::*;

  localparam int CW = $clog2(MAX_DIV);
  localparam int NSYNC = 7;

  initial begin
    if (MAX_DIV != `SCM_MAX_DIV) begin
      $error("Divide code table serves only MAX_DIV of 64");
    end
  end

  // Pins from outside the clock domain, two flops each; the third stage feeds edge detection
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [1:0] sync3;
  assign pin_raw = {I_CFG_TBC_LXT, I_CFG_SUB_LXT, I_CFG_HS_XTAL, I_HS_OSC_READY,
                    I_LS_OSC_READY, I_LS_RC_OSC_CLK, I_LXT_CLK};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sync3 <= 2'b00;
    end else begin
      sync3 <= sync2[1:0];
    end
  end

  logic lxt_tick;
  logic ls_rc_osc_tick;
  logic ls_ready;
  logic hs_ready;
  assign lxt_tick = sync2[0] & ~sync3[0];
  assign ls_rc_osc_tick = sync2[1] & ~sync3[1];
  assign ls_ready = sync2[2];
  assign hs_ready = sync2[3];

  // Configuration straps, caught once after reset release and frozen thereafter
  logic [1:0] strap_cnt;
  logic cfg_hs_xtal;
  logic cfg_sub_lxt;
  logic cfg_tbc_lxt;
  logic [1:0] next_strap_cnt;
  logic next_cfg_hs_xtal;
  logic next_cfg_sub_lxt;
  logic next_cfg_tbc_lxt;

  always_comb begin
    next_strap_cnt = strap_cnt;
    next_cfg_hs_xtal = cfg_hs_xtal;
    next_cfg_sub_lxt = cfg_sub_lxt;
    next_cfg_tbc_lxt = cfg_tbc_lxt;
    if (strap_cnt != 2'd3) begin
      next_strap_cnt = strap_cnt + 2'd1;
    end
    // RQ3 static source choices
    if (strap_cnt == `SCM_STRAP_WAIT) begin
      next_cfg_hs_xtal = sync2[4];
      next_cfg_sub_lxt = sync2[5];
      next_cfg_tbc_lxt = sync2[6];
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      strap_cnt <= 2'd0;
      cfg_hs_xtal <= 1'b0;
      cfg_sub_lxt <= 1'b0;
      cfg_tbc_lxt <= 1'b0;
    end else begin
      strap_cnt <= next_strap_cnt;
      cfg_hs_xtal <= next_cfg_hs_xtal;
      cfg_sub_lxt <= next_cfg_sub_lxt;
      cfg_tbc_lxt <= next_cfg_tbc_lxt;
    end
  end

  // RQ4 RQ5 low-speed sources
  logic sub_tick;
  logic tbc_tick;
  assign sub_tick = cfg_sub_lxt ? lxt_tick : ls_rc_osc_tick;
  assign tbc_tick = cfg_tbc_lxt ? lxt_tick : ls_rc_osc_tick;

  // Registers and bus slave
  logic [7:0] mode_reg;
  logic [7:0] ctrl_reg;
  logic ack;
  logic [31:0] readdata;
  logic [7:0] next_mode_reg;
  logic [7:0] next_ctrl_reg;
  logic next_ack;
  logic [31:0] next_readdata;
  logic req;
  logic wr_take;
  scm_mode_t mode;
  logic fast_sub;

  assign req = I_AVS_READ | I_AVS_WRITE;
  assign wr_take = I_AVS_WRITE & ack & I_AVS_BYTEENABLE[0];
  assign O_AVS_WAITREQUEST = req & ~ack;
  assign O_AVS_READDATA = readdata;

  always_comb begin
    next_ack = req & ~ack;
    next_mode_reg = mode_reg;
    next_ctrl_reg = ctrl_reg;
    next_readdata = readdata;
    if (I_AVS_READ && !ack) begin
      case (I_AVS_ADDRESS)
        // RQ18 ready flags read live
        `SCM_MODE_REG_OFF: begin
          next_readdata = {24'h000000, mode_reg};
          next_readdata[`SCM_F_LS_READY] = ls_ready;
          next_readdata[`SCM_F_HS_READY] = hs_ready;
        end
        `SCM_CTRL_REG_OFF: next_readdata = {28'h0000000, ctrl_reg[3:0]};
        `SCM_STAT_REG_OFF: begin
          next_readdata = {29'h00000000, mode};
          next_readdata[`SCM_F_STAT_FAST] = fast_sub;
          next_readdata[`SCM_F_STAT_HSON] = O_HS_OSC_EN;
        end
        default: next_readdata = 32'h00000000;
      endcase
    end
    if (wr_take && I_AVS_ADDRESS == `SCM_MODE_REG_OFF) begin
      // Ready flags are read-only and never stored
      next_mode_reg = I_AVS_WRITEDATA[7:0] & 8'hf3;
    end
    if (wr_take && I_AVS_ADDRESS == `SCM_CTRL_REG_OFF) begin
      next_ctrl_reg = {4'h0, I_AVS_WRITEDATA[3:0]};
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mode_reg <= `SCM_MODE_REG_RST;
      ctrl_reg <= `SCM_CTRL_REG_RST;
      ack <= 1'b0;
      readdata <= 32'h00000000;
    end else begin
      mode_reg <= next_mode_reg;
      ctrl_reg <= next_ctrl_reg;
      ack <= next_ack;
      readdata <= next_readdata;
    end
  end

  logic speed_sel;
  logic [2:0] div_sel;
  logic run_hs;
  logic halted;
  assign speed_sel = mode_reg[`SCM_F_SPEED];
  assign div_sel = mode_reg[`SCM_F_DIV_HI:`SCM_F_DIV_LO];
  // RQ2 codes 000 and 001 select sub_clk
  assign run_hs = speed_sel | (div_sel[2:1] != 2'b00);
  assign halted = (mode != SCM_NORMAL) && (mode != SCM_SLOW);

  // RQ1 divide code to counter mask; speed bit 1 gives the undivided clock
  function automatic logic [CW-1:0] div_mask(input logic spd, input logic [2:0] code);
    logic [CW-1:0] m;
    m = '1;
    if (spd) begin
      m = '0;
    end else if (code[2:1] != 2'b00) begin
      m = m >> (code - 3'd2);
    end
    return m;
  endfunction

  // Mode sequencing
  scm_mode_t next_mode;
  logic next_fast_sub;
  logic wdt_on_sub;
  assign wdt_on_sub = ctrl_reg[`SCM_F_WDT_EN] & ctrl_reg[`SCM_F_WDT_SUB];

  always_comb begin
    next_mode = mode;
    next_fast_sub = fast_sub;
    case (mode)
      SCM_NORMAL, SCM_SLOW: begin
        if (I_HALT) begin
          if (mode_reg[`SCM_F_IDLE_HALT]) begin
            // RQ15 RQ16 idle choice by clock-keep bit
            next_mode = ctrl_reg[`SCM_F_SYSCLK_KEEP] ? SCM_IDLE_CLK_RUN : SCM_IDLE_CLK_STOP;
          // RQ13 deep sleep refused under low-voltage detect
          end else if (ctrl_reg[`SCM_F_LVD_EN] || wdt_on_sub) begin
            next_mode = SCM_SLEEP_KEEP_SUB;
          end else begin
            // RQ11 sleep entry
            next_mode = SCM_DEEP_SLEEP;
          end
          next_fast_sub = 1'b0;
        end else begin
          // RQ8 RQ10 running mode follows the register
          next_mode = run_hs ? SCM_NORMAL : SCM_SLOW;
          if (hs_ready || !run_hs) begin
            next_fast_sub = 1'b0;
          end
        end
      end
      SCM_IDLE_CLK_STOP, SCM_IDLE_CLK_RUN, SCM_DEEP_SLEEP, SCM_SLEEP_KEEP_SUB: begin
        if (I_WAKE) begin
          // RQ19 resume per speed and divide bits
          next_mode = run_hs ? SCM_NORMAL : SCM_SLOW;
          // RQ6 RQ7 sub_clk stands in until the crystal is stable
          next_fast_sub = run_hs & mode_reg[`SCM_F_FAST_WAKE] & cfg_hs_xtal & ~hs_ready;
        end
      end
      default: begin
        next_mode = SCM_NORMAL;
        next_fast_sub = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mode <= SCM_NORMAL;
      fast_sub <= 1'b0;
    end else begin
      mode <= next_mode;
      fast_sub <= next_fast_sub;
    end
  end

  // Clock enables
  logic div_tick;
  logic use_hs;
  logic hs_on;
  logic sys_tick;
  assign use_hs = run_hs & ~fast_sub & (mode != SCM_SLOW);
  // RQ8 RQ10 high-speed oscillator only when it feeds something
  assign hs_on = (mode == SCM_NORMAL) || (mode == SCM_IDLE_CLK_RUN && run_hs);
  // Gated by ready so an unsettled crystal never reaches the processor
  assign sys_tick = use_hs ? (div_tick & hs_ready) : sub_tick;

  scm_clk_div #(
    .MAX_DIV(MAX_DIV)
  ) u_div (
    .i_clock(I_CLOCK),
    .i_sys_rst(I_SYS_RST),
    .i_run(hs_on & hs_ready),
    .i_div_mask(div_mask(speed_sel, div_sel)),
    .o_tick(div_tick)
  );

  logic next_cpu_en;
  logic next_sys_en;
  logic next_sub_en;
  logic next_tbc_en;
  logic next_wdt_run;
  logic next_periph;

  always_comb begin
    // RQ9 RQ10 processor clock in running modes only
    next_cpu_en = !halted && sys_tick;
    // RQ16 system clock survives only in idle_clk_run
    next_sys_en = (!halted || mode == SCM_IDLE_CLK_RUN) && sys_tick;
    // RQ12 RQ14 sub_clk off in deep sleep, kept in sleep_keep_sub only for a watchdog on sub_clk
    next_sub_en = sub_tick && (mode != SCM_DEEP_SLEEP) &&
                  (mode != SCM_SLEEP_KEEP_SUB || wdt_on_sub);
    next_tbc_en = tbc_tick && (mode != SCM_DEEP_SLEEP) && (mode != SCM_SLEEP_KEEP_SUB);
    next_wdt_run = ctrl_reg[`SCM_F_WDT_EN] && (mode != SCM_DEEP_SLEEP);
    // RQ17 peripherals live in running and idle modes
    next_periph = (mode != SCM_DEEP_SLEEP) && (mode != SCM_SLEEP_KEEP_SUB);
  end

  always_ff @(posedge I_CLOCK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_CPU_CLK_EN <= 1'b0;
      O_SYS_CLK_EN <= 1'b0;
      O_SUB_CLK_EN <= 1'b0;
      O_TBC_CLK_EN <= 1'b0;
      O_WDT_RUN <= 1'b0;
      O_PERIPH_RUN <= 1'b0;
    end else begin
      O_CPU_CLK_EN <= next_cpu_en;
      O_SYS_CLK_EN <= next_sys_en;
      O_SUB_CLK_EN <= next_sub_en;
      O_TBC_CLK_EN <= next_tbc_en;
      O_WDT_RUN <= next_wdt_run;
      O_PERIPH_RUN <= next_periph;
    end
  end

  assign O_HS_OSC_EN = hs_on;
  assign O_HS_XTAL_SEL = cfg_hs_xtal;
  assign O_MODE = mode;

  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (I_SYS_RST);

  a_halt_cpu_off: assert property (halted |=> !O_CPU_CLK_EN) // RQ11
    else $error("Processor clocked while halted");
  a_deep_refused: assert property (!halted && I_HALT && !mode_reg[1] && ctrl_reg[1]
    |=> mode == SCM_SLEEP_KEEP_SUB) // RQ13
    else $error("Deep sleep entered with low-voltage detect on");
  a_deep_clocks_off: assert property (mode == SCM_DEEP_SLEEP ##1 mode == SCM_DEEP_SLEEP
    |-> !O_SUB_CLK_EN && !O_TBC_CLK_EN && !O_WDT_RUN) // RQ12
    else $error("Clock or watchdog alive in deep sleep");
  a_slow_hs_off: assert property (mode == SCM_SLOW |-> !O_HS_OSC_EN) // RQ10
    else $error("High-speed oscillator on in slow mode");
  a_idle_stop_entry: assert property (!halted && I_HALT && mode_reg[1] && !ctrl_reg[0]
    |=> mode == SCM_IDLE_CLK_STOP && !O_HS_OSC_EN) // RQ15
    else $error("Idle clock-stop not entered");
  a_idle_run_entry: assert property (!halted && I_HALT && mode_reg[1] && ctrl_reg[0]
    |=> mode == SCM_IDLE_CLK_RUN) // RQ16
    else $error("Idle clock-run not entered");
  a_idle_periph: assert property ((mode == SCM_IDLE_CLK_STOP || mode == SCM_IDLE_CLK_RUN)
    |=> O_PERIPH_RUN && !O_CPU_CLK_EN) // RQ17
    else $error("Peripherals stopped in idle");
  a_wake_resume: assert property (halted && I_WAKE
    |=> mode == ($past(run_hs) ? SCM_NORMAL : SCM_SLOW)) // RQ19
    else $error("Wake-up resumed in wrong mode");
  a_ls_ready_read: assert property (I_AVS_READ && !ack && I_AVS_ADDRESS == 4'h0
    |=> O_AVS_READDATA[3] == $past(ls_ready) && !O_AVS_WAITREQUEST) // RQ18
    else $error("Low-speed ready flag misread");
  a_slow_sys_sub: assert property (mode == SCM_SLOW |=> O_SYS_CLK_EN == $past(sub_tick)) // RQ2
    else $error("Slow mode not clocked from sub_clk");

  c_deep_sleep: cover property (!halted ##1 mode == SCM_DEEP_SLEEP);
  c_idle_run: cover property (mode == SCM_IDLE_CLK_RUN ##1 mode == SCM_NORMAL);
  c_fast_wake: cover property (halted && I_WAKE ##1 fast_sub);
  c_keep_sub: cover property (mode == SCM_SLEEP_KEEP_SUB && O_SUB_CLK_EN);
endmodule
`default_nettype wire

// [logic/scm_consts.svh]
// Register offsets, field positions, reset values and timing for the clock and mode block
`ifndef SCM_CONSTS_SVH
`define SCM_CONSTS_SVH
`define SCM_MODE_REG_OFF 4'h0
`define SCM_CTRL_REG_OFF 4'h4
`define SCM_STAT_REG_OFF 4'h8
`define SCM_MODE_REG_RST 8'h03
`define SCM_CTRL_REG_RST 8'h00
`define SCM_F_SPEED 0
`define SCM_F_IDLE_HALT 1
`define SCM_F_HS_READY 2
`define SCM_F_LS_READY 3
`define SCM_F_FAST_WAKE 4
`define SCM_F_DIV_LO 5
`define SCM_F_DIV_HI 7
`define SCM_F_SYSCLK_KEEP 0
`define SCM_F_LVD_EN 1
`define SCM_F_WDT_EN 2
`define SCM_F_WDT_SUB 3
`define SCM_F_STAT_FAST 3
`define SCM_F_STAT_HSON 4
`define SCM_MAX_DIV 64
`define SCM_STRAP_WAIT 2'd2
`endif

// [logic/scm_pkg.sv]
// Types shared by the clock and mode block
package scm_pkg;
  typedef enum logic [2:0] {
    SCM_NORMAL = 3'b000,
    SCM_SLOW = 3'b001,
    SCM_IDLE_CLK_STOP = 3'b010,
    SCM_IDLE_CLK_RUN = 3'b011,
    SCM_DEEP_SLEEP = 3'b100,
    SCM_SLEEP_KEEP_SUB = 3'b101
  } scm_mode_t;
endpackage

// [logic/scm_clk_div.sv]
// Power-of-two divider of the high-speed clock, giving one enable pulse per divided period
`timescale 1ns/10ps
`default_nettype none
module scm_clk_div #(
  parameter int MAX_DIV = 64
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_run,
  input wire logic [$clog2(MAX_DIV)-1:0] i_div_mask,
  output logic o_tick
);
  localparam int CW = $clog2(MAX_DIV);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;

  initial begin
    if (MAX_DIV < 2 || (1 << CW) != MAX_DIV) begin
      $error("MAX_DIV must be a power of two of at least 2");
    end
  end

  always_comb begin
    next_cnt = i_run ? cnt + 1'b1 : '0;
    // Mask all ones marks the last cycle of each divided period
    o_tick = i_run && ((cnt & i_div_mask) == i_div_mask);
  end

  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule
`default_nettype wire

// [sim/scm_top_bench.sv]
// Self-checking bench for clock selection and operating mode sequencing
`timescale 1ns/10ps
`default_nettype none
`include "scm_consts.svh"
module scm_top_bench;
  import scm_pkg::*;
  logic I_CLOCK = 1'b0;
  logic I_SYS_RST = 1'b1;
  logic [3:0] I_AVS_ADDRESS = 4'h0;
  logic [3:0] I_AVS_BYTEENABLE = 4'hf;
  logic I_AVS_READ = 1'b0;
  logic I_AVS_WRITE = 1'b0;
  logic [31:0] I_AVS_WRITEDATA = 32'h0;
  logic I_HALT = 1'b0;
  logic I_WAKE = 1'b0;
  logic I_LXT_CLK = 1'b0;
  logic I_LS_RC_OSC_CLK = 1'b0;
  logic I_LS_OSC_READY = 1'b1;
  logic I_HS_OSC_READY = 1'b1;
  logic I_CFG_HS_XTAL = 1'b1;
  logic I_CFG_SUB_LXT = 1'b1;
  logic I_CFG_TBC_LXT = 1'b0;
  logic [31:0] O_AVS_READDATA;
  logic O_AVS_WAITREQUEST, O_HS_XTAL_SEL, O_HS_OSC_EN, O_CPU_CLK_EN, O_SYS_CLK_EN;
  logic O_SUB_CLK_EN, O_TBC_CLK_EN, O_WDT_RUN, O_PERIPH_RUN;
  scm_mode_t O_MODE;
  int n_fail = 0;
  int checks = 0;
  int n_cpu, n_sys, n_sub, n_tbc, n;
  logic [3:0] lxt_cnt = 4'h0;
  logic [3:0] ls_rc_osc_cnt = 4'h0;
  logic [31:0] rd;

  scm_top i_dut (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .I_AVS_ADDRESS(I_AVS_ADDRESS),
    .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_AVS_WRITEDATA(I_AVS_WRITEDATA),
    .I_AVS_BYTEENABLE(I_AVS_BYTEENABLE), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_HALT(I_HALT), .I_WAKE(I_WAKE),
    .I_LXT_CLK(I_LXT_CLK), .I_LS_RC_OSC_CLK(I_LS_RC_OSC_CLK), .I_LS_OSC_READY(I_LS_OSC_READY),
    .I_HS_OSC_READY(I_HS_OSC_READY), .I_CFG_HS_XTAL(I_CFG_HS_XTAL),
    .I_CFG_SUB_LXT(I_CFG_SUB_LXT), .I_CFG_TBC_LXT(I_CFG_TBC_LXT),
    .O_HS_XTAL_SEL(O_HS_XTAL_SEL), .O_HS_OSC_EN(O_HS_OSC_EN), .O_CPU_CLK_EN(O_CPU_CLK_EN),
    .O_SYS_CLK_EN(O_SYS_CLK_EN), .O_SUB_CLK_EN(O_SUB_CLK_EN), .O_TBC_CLK_EN(O_TBC_CLK_EN),
    .O_WDT_RUN(O_WDT_RUN), .O_PERIPH_RUN(O_PERIPH_RUN), .O_MODE(O_MODE));

  always #2 I_CLOCK = ~I_CLOCK;

  // Crystal period 16 cycles, RC period 10, so both divide the 320-cycle count window
  always @(posedge I_CLOCK) begin
    lxt_cnt <= lxt_cnt + 4'h1;
    ls_rc_osc_cnt <= (ls_rc_osc_cnt == 4'h9) ? 4'h0 : ls_rc_osc_cnt + 4'h1;
    I_LXT_CLK <= lxt_cnt[3];
    I_LS_RC_OSC_CLK <= (ls_rc_osc_cnt >= 4'h5);
  end

  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
      input logic [3:0] be);
    int t;
    t = 0;
    @(posedge I_CLOCK);
    I_AVS_READ <= ~w;
    I_AVS_WRITE <= w;
    I_AVS_ADDRESS <= a;
    I_AVS_WRITEDATA <= {24'h0, d};
    I_AVS_BYTEENABLE <= be;
    do begin
      @(posedge I_CLOCK);
      t++;
    end while (O_AVS_WAITREQUEST !== 1'b0 && t < 50);
    rd = O_AVS_READDATA;
    I_AVS_READ <= 1'b0;
    I_AVS_WRITE <= 1'b0;
    if (t >= 50)
      chk("waitrequest", 32'h0, 32'h1);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdc(input string name, input logic [3:0] a, input logic [31:0] exp,
      input logic [31:0] m);
    bus(1'b0, a, 8'h0, 4'hf);
    chk(name, exp, rd & m);
  endtask

  task automatic md(input scm_mode_t e);
    repeat (2) @(posedge I_CLOCK);
    chk("mode", {29'h0, e}, {29'h0, O_MODE});
  endtask

  task automatic pulse(input logic h);
    @(posedge I_CLOCK);
    if (h)
      I_HALT <= 1'b1;
    else
      I_WAKE <= 1'b1;
    @(posedge I_CLOCK);
    I_HALT <= 1'b0;
    I_WAKE <= 1'b0;
    repeat (4) @(posedge I_CLOCK);
  endtask

  // Settle first: the divider and synchronisers need time after a mode change
  task automatic cnt;
    n_cpu = 0;
    n_sys = 0;
    n_sub = 0;
    n_tbc = 0;
    repeat (80) @(posedge I_CLOCK);
    repeat (320) begin
      @(posedge I_CLOCK);
      #1;
      n_cpu += int'(O_CPU_CLK_EN === 1'b1);
      n_sys += int'(O_SYS_CLK_EN === 1'b1);
      n_sub += int'(O_SUB_CLK_EN === 1'b1);
      n_tbc += int'(O_TBC_CLK_EN === 1'b1);
    end
  endtask

  task automatic ens(input int c, input int s, input int u, input int t);
    cnt;
    chk("cpu pulses", c, n_cpu);
    chk("sys pulses", s, n_sys);
    chk("sub pulses", u, n_sub);
    chk("tbc pulses", t, n_tbc);
  endtask

  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end

  initial begin
    repeat (2) @(posedge I_CLOCK);
    I_SYS_RST <= 1'b0;
    repeat (4) @(posedge I_CLOCK);
    rdc("mode reg", `SCM_MODE_REG_OFF, 32'h0f, '1);
    rdc("ctrl reg", `SCM_CTRL_REG_OFF, 32'h00, '1);
    rdc("unmapped", 4'hc, 32'h0, '1);
    md(SCM_NORMAL);
    chk("xtal strap", 32'h1, {31'h0, O_HS_XTAL_SEL});
    I_LS_OSC_READY <= 1'b0;
    wr(`SCM_MODE_REG_OFF, 8'hfe);
    rdc("ro bits", `SCM_MODE_REG_OFF, 32'hf6, '1);
    I_LS_OSC_READY <= 1'b1;
    bus(1'b1, `SCM_MODE_REG_OFF, 8'h00, 4'h0);
    rdc("lane off", `SCM_MODE_REG_OFF, 32'hfe, '1);
    for (int c = 0; c < 8; c++) begin
      wr(`SCM_MODE_REG_OFF, {c[2:0], 5'h0});
      n = (c < 2) ? 20 : 320 >> (8 - c);
      md((c < 2) ? SCM_SLOW : SCM_NORMAL);
      chk("hs osc en", 32'(c >= 2), {31'h0, O_HS_OSC_EN});
      ens(n, n, 20, 32);
    end
    wr(`SCM_MODE_REG_OFF, 8'h01);
    ens(320, 320, 20, 32);
    wr(`SCM_CTRL_REG_OFF, 8'h04);
    pulse(1'b1);
    md(SCM_DEEP_SLEEP);
    chk("wdt run", 32'h0, {31'h0, O_WDT_RUN});
    ens(0, 0, 0, 0);
    pulse(1'b1);
    md(SCM_DEEP_SLEEP);
    pulse(1'b0);
    md(SCM_NORMAL);
    pulse(1'b0);
    md(SCM_NORMAL);
    ens(320, 320, 20, 32);
    wr(`SCM_CTRL_REG_OFF, 8'h02);
    pulse(1'b1);
    md(SCM_SLEEP_KEEP_SUB);
    pulse(1'b0);
    wr(`SCM_CTRL_REG_OFF, 8'h0c);
    pulse(1'b1);
    md(SCM_SLEEP_KEEP_SUB);
    chk("wdt run", 32'h1, {31'h0, O_WDT_RUN});
    ens(0, 0, 20, 0);
    pulse(1'b0);
    wr(`SCM_MODE_REG_OFF, 8'h03);
    wr(`SCM_CTRL_REG_OFF, 8'h00);
    pulse(1'b1);
    md(SCM_IDLE_CLK_STOP);
    rdc("status", `SCM_STAT_REG_OFF, 32'h02, 32'h1f);
    chk("periph run", 32'h1, {31'h0, O_PERIPH_RUN});
    ens(0, 0, 20, 32);
    pulse(1'b0);
    wr(`SCM_CTRL_REG_OFF, 8'h01);
    pulse(1'b1);
    md(SCM_IDLE_CLK_RUN);
    rdc("status", `SCM_STAT_REG_OFF, 32'h13, 32'h1f);
    chk("periph run", 32'h1, {31'h0, O_PERIPH_RUN});
    ens(0, 320, 20, 32);
    pulse(1'b0);
    wr(`SCM_CTRL_REG_OFF, 8'h00);
    wr(`SCM_MODE_REG_OFF, 8'h11);
    I_HS_OSC_READY <= 1'b0;
    pulse(1'b1);
    pulse(1'b0);
    rdc("fast wake", `SCM_STAT_REG_OFF, 32'h08, 32'h0f);
    cnt;
    chk("sub as cpu clock", 32'd20, n_cpu);
    I_HS_OSC_READY <= 1'b1;
    repeat (6) @(posedge I_CLOCK);
    rdc("fast end", `SCM_STAT_REG_OFF, 32'h00, 32'h0f);
    wr(`SCM_MODE_REG_OFF, 8'h01);
    I_HS_OSC_READY <= 1'b0;
    pulse(1'b1);
    pulse(1'b0);
    rdc("no fast", `SCM_STAT_REG_OFF, 32'h00, 32'h0f);
    I_HS_OSC_READY <= 1'b1;
    end_of_test;
  end
endmodule
`default_nettype wire
